// *** common/pcs_pkg.sv ***
// Package for the clock conditioner configuration block
package pcs_pkg;
   localparam int CFG_W = 32;
   // Field positions in the configuration word
   localparam int FB_SRC_LSB = 0;
   localparam int FB_SRC_W = 2;
   localparam int DESKEW_BIT = 2;
   localparam int PRI_SEL_LSB = 3;
   localparam int PRI_SEL_W = 3;
   localparam int SEC_SEL_LSB = 6;
   localparam int SEC_SEL_W = 2;
   localparam int PRI_DLY_LSB = 8;
   localparam int SEC_DLY_LSB = 10;
   localparam int DLY_W = 2;
   localparam int FB_DLY_LSB = 12;
   localparam int FB_DLY_W = 4;
   localparam int IN_DIV_LSB = 16;
   localparam int IN_DIV_W = 5;
   localparam int FB_DIV_LSB = 21;
   localparam int FB_DIV_W = 6;
   localparam int PRI_DIV_LSB = 27;
   localparam int SEC_DIV_LSB = 29;
   localparam int OUT_DIV_W = 2;
   // Register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_FIXED = 12'h004;
   localparam logic [11:0] ADDR_SHIFT = 12'h008;
   localparam logic [11:0] ADDR_ACTIVE = 12'h00C;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   // Control register bits
   localparam int CTRL_DYN_BIT = 0;
   localparam int CTRL_SRC_BIT = 1;
   localparam int CTRL_LOAD_BIT = 2;
   // Reset values
   localparam logic [31:0] FIXED_RST = 32'h0000_0020;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // Lock qualification: cycles of steady reference before lock
   localparam int LOCK_CYC = 64;
   localparam int LOCK_CW = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] sec_div;
      logic [1:0] pri_div;
      logic [5:0] fb_div;
      logic [4:0] in_div;
      logic [3:0] feedback_delay_line;
      logic [1:0] secondary_output_delay;
      logic [1:0] primary_output_delay;
      logic [1:0] secondary_output_select;
      logic [2:0] primary_output_select;
      logic ext_feedback_deskew_select;
      logic [1:0] feedback_source_select;
   } pcs_cfg_t;

   typedef enum logic [2:0] {
      LK_IDLE = 3'b001,
      LK_ACQ = 3'b010,
      LK_LOCK = 3'b100
   } pcs_lock_t;
endpackage

// *** rtl/pcs_clock_config.sv ***
// Clock conditioner configuration, shift register, select decode and lock tracking
// Contract
// [RULE1] Feedback code 1 internal, 2 internal advanced by delay line, 3 external input.
// [RULE2] Deskew select 0 leaves feedback alone, 1 advances it by fixed system delay.
// [RULE3] Primary select 0 bypass, 1 bypass through divider, 2 delayed clock.
// [RULE4] Primary select 4 to 7 give PLL output at 0, 90, 180, 270 degrees.
// [RULE5] Secondary select 0/1 bypass without/with divider, 2 delayed, 3 PLL at 0 degrees.
// [RULE6] Each output delay line gives 0, 0.25, 0.50 or 4.0 ns for codes 0..3.
// [RULE7] Active-high lock output asserts once the loop is locked to the reference.
// [RULE8] Lock held while reference jitter stays inside tolerance.
// [RULE9] Downstream logic may use lock as soft reset while low.
// [RULE10] With reference out of range, clock and lock are indeterminate.
// [RULE11] Settings come from fixed bits or from dynamic bits at run time.
// [RULE12] Dynamic bits shift in serially, then drive the controls in parallel.
// [RULE13] Shift register loadable from user logic or JTAG; loader drives data and shift.
// [RULE14] Delaying the reference alone bypasses the core through the output delay line.
// [RULE15] Feedback-path delay advances the output relative to the input.
// [RULE16] Feedback from the clock network aligns it with the reference for near-zero skew.
// [RULE17] Input divider 1 to 32, feedback divider 1 to 64.
// [RULE18] Core output equals reference times feedback divider over input divider.
// [RULE19] Each global output has its own divider of 1 to 4.
// [RULE20] Feedback delay line spans 0 to 4 ns in 250 ps steps.
// [RULE21] Loader avoids undocumented select codes such as primary code 3.
// [RULE22] After reconfiguring, downstream waits for lock to reassert.
module pcs_clock_config
   import pcs_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // AXI4-Lite slave
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [11:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Serial loader from JTAG
   input wire logic JTAG_SHIFT,
   input wire logic JTAG_SDI,
   input wire logic JTAG_UPDATE,
   // Serial loader from user logic (same clock)
   input wire logic USER_SHIFT,
   input wire logic USER_SDI,
   input wire logic USER_UPDATE,
   // Reference status from the analog core
   input wire logic REF_IN_RANGE,
   input wire logic CORE_PHASE_OK,
   // Decoded controls towards the analog core and muxes
   output pcs_cfg_t ACTIVE_CFG,
   output logic [1:0] FB_PATH_SEL,
   output logic FB_ADVANCE_EN,
   output logic [3:0] PRI_PHASE_ONEHOT,
   output logic PRI_USE_DIV,
   output logic PRI_USE_PLL,
   output logic SEC_USE_DIV,
   output logic SEC_USE_PLL,
   output logic [9:0] PRI_DELAY_STEPS,
   output logic [9:0] SEC_DELAY_STEPS,
   output logic [4:0] FB_DELAY_STEPS,
   output logic [5:0] IN_DIV_FACTOR,
   output logic [6:0] FB_MUL_FACTOR,
   output logic [2:0] PRI_DIV_FACTOR,
   output logic [2:0] SEC_DIV_FACTOR,
   output logic LOCK
);
   // Delay line in 0.25 ns steps: 0, 1, 2 or 16 steps
   function automatic logic [9:0] dly_steps(input logic [1:0] code);
      dly_steps = (code == 2'h3) ? 10'h010 : {8'h00, code}; // RULE6
   endfunction

   // Two-stage sync for JTAG-side signals
   // The third JTAG stage only feeds the edge detectors, never the logic itself
   logic [2:0] jt_s1_ff, jt_s2_ff, jt_s3_ff;
   logic [1:0] ref_s1_ff, ref_s2_ff;
   logic [31:0] ctrl_ff, fixed_ff, shift_ff, dyn_ff, nxt_shift;
   logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
   logic [11:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [LOCK_CW-1:0] lock_cnt_ff;
   pcs_lock_t lk_ff, nxt_lk;
   pcs_cfg_t cfg_ff;
   logic lock_ff;
   logic [31:0] cfg_sel_w;
   // Bit 31 of the word carries no field; it is cut here so a stray write
   // to it can neither reach the controls nor hold off lock
   localparam pcs_cfg_t RST_CFG = pcs_cfg_t'(FIXED_RST[30:0]);
   pcs_cfg_t cfg_sel_c;

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         jt_s1_ff <= 3'h0;
         jt_s2_ff <= 3'h0;
         jt_s3_ff <= 3'h0;
         ref_s1_ff <= 2'h0;
         ref_s2_ff <= 2'h0;
      end else begin
         jt_s1_ff <= {JTAG_UPDATE, JTAG_SHIFT, JTAG_SDI};
         jt_s2_ff <= jt_s1_ff;
         jt_s3_ff <= jt_s2_ff;
         ref_s1_ff <= {CORE_PHASE_OK, REF_IN_RANGE};
         ref_s2_ff <= ref_s1_ff;
      end
   end

   // JTAG shift clock arrives as a level; one shift per rising edge of the synced strobe
   // Only the selected loader moves the register; the other one is ignored
   wire jtag_src = ctrl_ff[CTRL_SRC_BIT]; // RULE13
   wire jt_shift_ev = jt_s2_ff[1] & ~jt_s3_ff[1];
   wire jt_upd_ev = jt_s2_ff[2] & ~jt_s3_ff[2];
   wire shift_en = jtag_src ? jt_shift_ev : USER_SHIFT; // RULE13
   wire shift_bit = jtag_src ? jt_s2_ff[0] : USER_SDI;
   wire upd_en = jtag_src ? jt_upd_ev : USER_UPDATE;

   // AXI write decode
   wire wr_go = aw_ff & w_ff & ~bvalid_ff;
   wire wr_ctrl = wr_go & (awaddr_ff == ADDR_CTRL);
   wire wr_fixed = wr_go & (awaddr_ff == ADDR_FIXED);
   wire wr_shift = wr_go & (awaddr_ff == ADDR_SHIFT);
   // Unmapped offsets still answer, with an error code
   wire wr_hit = wr_ctrl | wr_fixed | wr_shift | (awaddr_ff == ADDR_ACTIVE)
      | (awaddr_ff == ADDR_STATUS);
   wire sw_load = wr_ctrl & wdata_ff[CTRL_LOAD_BIT];
   wire [31:0] strb_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}},
      {8{wstrb_ff[0]}}};

   // Serial in at the top, older bits move toward bit 0
   // A register write beats a shift in the same cycle; software owns that cycle
   always_comb begin
      nxt_shift = shift_ff;
      if (shift_en) begin
         nxt_shift = {shift_bit, shift_ff[31:1]}; // RULE12
      end
      if (wr_shift) begin
         nxt_shift = (shift_ff & ~strb_mask) | (wdata_ff & strb_mask);
      end
   end

   // Software load or loader update copies the shifted word to the parallel side
   wire dyn_load = upd_en | sw_load; // RULE12
   assign cfg_sel_w = ctrl_ff[CTRL_DYN_BIT] ? dyn_ff : fixed_ff; // RULE11
   assign cfg_sel_c = pcs_cfg_t'(cfg_sel_w[30:0]);

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         ctrl_ff <= CTRL_RST;
         fixed_ff <= FIXED_RST;
         shift_ff <= 32'h0000_0000;
         dyn_ff <= FIXED_RST;
         cfg_ff <= RST_CFG;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= {29'h0, 1'b0, wdata_ff[CTRL_SRC_BIT], wdata_ff[CTRL_DYN_BIT]};
         end
         if (wr_fixed) begin
            fixed_ff <= (fixed_ff & ~strb_mask) | (wdata_ff & strb_mask);
         end
         shift_ff <= nxt_shift;
         if (dyn_load) begin
            dyn_ff <= shift_ff;
         end
         cfg_ff <= cfg_sel_c; // RULE11
      end
   end

   // AXI write channel: address and data taken in either order
   // A held half drops its ready until the response is taken; one write at a time
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 12'h000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID & ~aw_ff & ~bvalid_ff) begin
            aw_ff <= 1'b1;
            awaddr_ff <= {S_AXI_AWADDR[11:2], 2'h0};
         end
         if (S_AXI_WVALID & ~w_ff & ~bvalid_ff) begin
            w_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
         end
         if (bvalid_ff & S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // AXI read channel
   // Read data is registered, so the answer stands one cycle after the address
   wire [11:0] ra = {S_AXI_ARADDR[11:2], 2'h0};
   wire rd_go = S_AXI_ARVALID & ~rvalid_ff;
   wire [31:0] status_w = {28'h0, lk_ff, lock_ff};
   wire rd_hit = (ra == ADDR_CTRL) | (ra == ADDR_FIXED) | (ra == ADDR_SHIFT)
      | (ra == ADDR_ACTIVE) | (ra == ADDR_STATUS);
   wire [31:0] rd_mux = (ra == ADDR_CTRL) ? ctrl_ff :
      (ra == ADDR_FIXED) ? fixed_ff :
      (ra == ADDR_SHIFT) ? shift_ff :
      (ra == ADDR_ACTIVE) ? 32'(cfg_ff) :
      (ra == ADDR_STATUS) ? status_w : 32'h0000_0000;

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_mux;
         rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff & S_AXI_RREADY) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Lock tracking: a config change or out-of-range reference drops lock
   // Lock needs LOCK_CYC quiet cycles; the count restarts on any change
   wire ref_ok = ref_s2_ff[0] & ref_s2_ff[1]; // RULE10
   wire cfg_chg = (cfg_sel_c != cfg_ff); // RULE22
   always_comb begin
      nxt_lk = lk_ff;
      unique case (lk_ff)
         LK_IDLE: if (ref_ok) nxt_lk = LK_ACQ;
         LK_ACQ: begin
            if (!ref_ok | cfg_chg) nxt_lk = LK_IDLE;
            else if (lock_cnt_ff == LOCK_CW'(LOCK_CYC - 1)) nxt_lk = LK_LOCK; // RULE7
         end
         LK_LOCK: if (!ref_ok | cfg_chg) nxt_lk = LK_IDLE; // RULE8
         default: nxt_lk = LK_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         lk_ff <= LK_IDLE;
         lock_cnt_ff <= '0;
         lock_ff <= 1'b0;
      end else begin
         lk_ff <= nxt_lk;
         lock_cnt_ff <= (nxt_lk == LK_ACQ) ? lock_cnt_ff + 1'b1 : '0;
         lock_ff <= (nxt_lk == LK_LOCK); // RULE7
      end
   end

   // Decode of the active configuration
   wire [1:0] fbs = cfg_ff.feedback_source_select;
   wire [2:0] pri = cfg_ff.primary_output_select;
   wire [1:0] sec = cfg_ff.secondary_output_select;
   wire [4:0] fb_steps = {1'b0, cfg_ff.feedback_delay_line} + 5'h01; // RULE20
   // Advance enable: feedback delay line or external deskew, either one moves the output earlier
   wire fb_adv = (fbs == 2'h2) | ((fbs == 2'h3) & cfg_ff.ext_feedback_deskew_select); // RULE15
   // The one delay line is shared, so any path that names it turns it on
   wire fb_dly_used = (fbs == 2'h2) | (pri == 3'h2) | (sec == 2'h2);

   // Named next values keep the output register block to plain copies
   wire [1:0] nxt_fb_path = fbs; // RULE1 RULE16
   wire [3:0] nxt_pri_onehot = pri[2] ? (4'h1 << pri[1:0]) : 4'h0; // RULE4
   wire nxt_pri_use_div = (pri == 3'h1); // RULE3
   wire nxt_pri_use_pll = pri[2]; // RULE3 RULE14
   wire nxt_sec_use_div = (sec == 2'h1); // RULE5
   wire nxt_sec_use_pll = (sec == 2'h3); // RULE5
   wire [9:0] nxt_pri_dly = dly_steps(cfg_ff.primary_output_delay); // RULE6 RULE14
   wire [9:0] nxt_sec_dly = dly_steps(cfg_ff.secondary_output_delay); // RULE6
   wire [4:0] nxt_fb_dly = fb_dly_used ? fb_steps : 5'h00; // RULE20
   // Divider fields hold the factor minus one, so an all-zero word divides by one
   wire [5:0] nxt_in_div = {1'b0, cfg_ff.in_div} + 6'h01; // RULE17 RULE18
   wire [6:0] nxt_fb_mul = {1'b0, cfg_ff.fb_div} + 7'h01; // RULE17 RULE18
   wire [2:0] nxt_pri_div = {1'b0, cfg_ff.pri_div} + 3'h1; // RULE19
   wire [2:0] nxt_sec_div = {1'b0, cfg_ff.sec_div} + 3'h1; // RULE19
   // Gating on the live reference shows a lost reference one cycle sooner
   wire nxt_lock = lock_ff & ref_ok; // RULE7 RULE9

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         // Reset values are the decode of the reset word: primary select 4, 0 degrees
         ACTIVE_CFG <= RST_CFG;
         FB_PATH_SEL <= 2'h0;
         FB_ADVANCE_EN <= 1'b0;
         PRI_PHASE_ONEHOT <= 4'h1;
         PRI_USE_DIV <= 1'b0;
         PRI_USE_PLL <= 1'b1;
         SEC_USE_DIV <= 1'b0;
         SEC_USE_PLL <= 1'b0;
         PRI_DELAY_STEPS <= 10'h000;
         SEC_DELAY_STEPS <= 10'h000;
         FB_DELAY_STEPS <= 5'h00;
         IN_DIV_FACTOR <= 6'h01;
         FB_MUL_FACTOR <= 7'h01;
         PRI_DIV_FACTOR <= 3'h1;
         SEC_DIV_FACTOR <= 3'h1;
         LOCK <= 1'b0;
      end else begin
         ACTIVE_CFG <= cfg_ff;
         FB_PATH_SEL <= nxt_fb_path; // RULE1 RULE16
         FB_ADVANCE_EN <= fb_adv; // RULE1 RULE2
         PRI_PHASE_ONEHOT <= nxt_pri_onehot; // RULE4
         PRI_USE_DIV <= nxt_pri_use_div; // RULE3
         PRI_USE_PLL <= nxt_pri_use_pll; // RULE3 RULE14
         SEC_USE_DIV <= nxt_sec_use_div; // RULE5
         SEC_USE_PLL <= nxt_sec_use_pll; // RULE5
         PRI_DELAY_STEPS <= nxt_pri_dly; // RULE6 RULE14
         SEC_DELAY_STEPS <= nxt_sec_dly; // RULE6
         FB_DELAY_STEPS <= nxt_fb_dly; // RULE20
         IN_DIV_FACTOR <= nxt_in_div; // RULE17 RULE18
         FB_MUL_FACTOR <= nxt_fb_mul; // RULE17 RULE18
         PRI_DIV_FACTOR <= nxt_pri_div; // RULE19
         SEC_DIV_FACTOR <= nxt_sec_div; // RULE19
         LOCK <= nxt_lock; // RULE7 RULE9
      end
   end

   assign S_AXI_AWREADY = ~aw_ff & ~bvalid_ff;
   assign S_AXI_WREADY = ~w_ff & ~bvalid_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_ARREADY = ~rvalid_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;
endmodule

// *** dv/pcs_clock_config_sva.sv ***
// Checks on decoded clock controls and lock of the configuration block
module pcs_clock_config_sva
   import pcs_pkg::*;
(
   input logic CLK_SYS,
   input logic RSTN,
   input logic REF_IN_RANGE,
   input logic CORE_PHASE_OK,
   input pcs_cfg_t ACTIVE_CFG,
   input logic [1:0] FB_PATH_SEL,
   input logic FB_ADVANCE_EN,
   input logic [3:0] PRI_PHASE_ONEHOT,
   input logic PRI_USE_DIV,
   input logic PRI_USE_PLL,
   input logic SEC_USE_DIV,
   input logic SEC_USE_PLL,
   input logic [9:0] PRI_DELAY_STEPS,
   input logic [9:0] SEC_DELAY_STEPS,
   input logic [4:0] FB_DELAY_STEPS,
   input logic [5:0] IN_DIV_FACTOR,
   input logic [6:0] FB_MUL_FACTOR,
   input logic [2:0] PRI_DIV_FACTOR,
   input logic [2:0] SEC_DIV_FACTOR,
   input logic LOCK
);
   wire pcs_cfg_t ac = ACTIVE_CFG;
   logic [7:0] ok_ff;
   wire logic [1:0] fs = ac.feedback_source_select;
   wire logic [2:0] ps = ac.primary_output_select;
   wire logic [1:0] ss = ac.secondary_output_select;
   wire logic [1:0] pd = ac.primary_output_delay;
   wire logic [1:0] sd = ac.secondary_output_delay;
   wire logic ok = REF_IN_RANGE && CORE_PHASE_OK;
   wire logic [7:0] nxt_ok = !ok ? 8'h0 : ok_ff + {7'h0, ~&ok_ff};
   // Decodes are registered beside the active word; the raw ok run bounds any lock
   always_ff @(posedge CLK_SYS) begin
      ok_ff <= RSTN ? nxt_ok : 8'h0;
   end
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);
   fb_sel_a: assert property (FB_PATH_SEL == fs && FB_ADVANCE_EN ==
      (fs == 2'h2 || fs == 2'h3 && ac.ext_feedback_deskew_select)) else $error("feedback");
   pri_phase_a: assert property (PRI_PHASE_ONEHOT == (ps[2] ? 4'h1 << ps[1:0] : 4'h0))
      else $error("phase");
   pri_mux_a: assert property (PRI_USE_DIV == (ps == 3'h1) && PRI_USE_PLL == ps[2])
      else $error("primary mux");
   sec_mux_a: assert property (SEC_USE_DIV == (ss == 2'h1) && SEC_USE_PLL == (ss == 2'h3))
      else $error("secondary mux");
   out_dly_a: assert property (PRI_DELAY_STEPS == (pd == 2'h3 ? 10'h010 : 10'(pd)) &&
      SEC_DELAY_STEPS == (sd == 2'h3 ? 10'h010 : 10'(sd))) else $error("output delay");
   fb_dly_a: assert property (FB_DELAY_STEPS == ((fs == 2'h2 || ps == 3'h2 || ss == 2'h2) ?
      5'(ac.feedback_delay_line) + 5'h1 : 5'h0)) else $error("feedback delay");
   div_fact_a: assert property (IN_DIV_FACTOR == 6'(ac.in_div) + 6'h1 &&
      FB_MUL_FACTOR == 7'(ac.fb_div) + 7'h1 && PRI_DIV_FACTOR == 3'(ac.pri_div) + 3'h1 &&
      SEC_DIV_FACTOR == 3'(ac.sec_div) + 3'h1) else $error("divider");
   lock_qual_a: assert property ($rose(LOCK) |-> ok_ff >= 8'(LOCK_CYC))
      else $error("early lock");
   lock_loss_a: assert property (!ok |-> ##[1:5] !LOCK)
      else $error("lock kept");
endmodule
bind pcs_clock_config pcs_clock_config_sva u_sva (.CLK_SYS, .RSTN, .REF_IN_RANGE,
   .CORE_PHASE_OK, .ACTIVE_CFG, .FB_PATH_SEL, .FB_ADVANCE_EN, .PRI_PHASE_ONEHOT, .PRI_USE_DIV,
   .PRI_USE_PLL, .SEC_USE_DIV, .SEC_USE_PLL, .PRI_DELAY_STEPS, .SEC_DELAY_STEPS,
   .FB_DELAY_STEPS, .IN_DIV_FACTOR, .FB_MUL_FACTOR, .PRI_DIV_FACTOR, .SEC_DIV_FACTOR, .LOCK);

// *** dv/pcs_loader_model.sv ***
// Partner model: serial configuration loader on the user or JTAG port
module pcs_loader_model (
   input logic clk,
   output logic u_sh,
   output logic u_d,
   output logic u_up,
   output logic j_sh,
   output logic j_d,
   output logic j_up
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {u_sh, u_d, u_up, j_sh, j_d, j_up} = 6'h0;
   // JTAG levels pass a synchroniser, so each one is held four cycles
   task automatic jt(input logic s, input logic u);
      j_sh <= s;
      j_up <= u;
      repeat (4) @(posedge clk);
   endtask
   // Bit 0 goes first and ends in bit 0 after 32 right shifts
   task automatic load(input logic [31:0] w, input logic jtag);
      for (int k = 0; k < 32; k++) begin
         @(posedge clk);
         u_sh <= !jtag;
         u_d <= w[k];
         j_d <= w[k];
         if (jtag) begin
            jt(1'b0, 1'b0);
            jt(1'b1, 1'b0);
         end
      end
      @(posedge clk);
      u_sh <= 1'b0;
      u_d <= ~u_d;
      j_d <= ~j_d;
      u_up <= !jtag;
      if (jtag) jt(1'b0, 1'b1);
      @(posedge clk);
      u_up <= 1'b0;
      j_up <= 1'b0;
   endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench for the clock conditioner configuration block
module tb_top
   import pcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [33:0] WOK = {RESP_OKAY, 32'h0};
   logic clk, rstn, awv, wv, br, arv, rr, ref_ok, ph_ok, lock, awr, wrdy, bv, arr, rv;
   logic us, ud, uu, js, jd, ju;
   logic [1:0] bresp, rresp;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd, w, f;
   logic [33:0] q[$];
   int seed, error_cnt, total_checks, i, n;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   pcs_loader_model ldr (.clk(clk), .u_sh(us), .u_d(ud), .u_up(uu), .j_sh(js), .j_d(jd),
      .j_up(ju));
   pcs_clock_config dut (.CLK_SYS(clk), .RSTN(rstn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .JTAG_SHIFT(js),
      .JTAG_SDI(jd), .JTAG_UPDATE(ju), .USER_SHIFT(us), .USER_SDI(ud), .USER_UPDATE(uu),
      .REF_IN_RANGE(ref_ok), .CORE_PHASE_OK(ph_ok), .ACTIVE_CFG(), .FB_PATH_SEL(),
      .FB_ADVANCE_EN(), .PRI_PHASE_ONEHOT(), .PRI_USE_DIV(), .PRI_USE_PLL(), .SEC_USE_DIV(),
      .SEC_USE_PLL(), .PRI_DELAY_STEPS(), .SEC_DELAY_STEPS(), .FB_DELAY_STEPS(),
      .IN_DIV_FACTOR(), .FB_MUL_FACTOR(), .PRI_DIV_FACTOR(), .SEC_DIV_FACTOR(), .LOCK(lock));
   task automatic chk(input string nm, input logic [33:0] x, input logic [33:0] g);
      total_checks++;
      if (g !== x) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One bus transfer; the expected response is queued before the request goes out
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] x);
      q.push_back(x);
      @(posedge clk);
      awa <= a;
      ara <= a;
      wd <= d;
      awv <= wr;
      wv <= wr;
      br <= wr;
      arv <= !wr;
      rr <= !wr;
      // No cycle limit here: only the watchdog ends a wait
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
         if (arv && arr) arv <= 1'b0;
      end while (!(br && bv || rr && rv));
      br <= 1'b0;
      rr <= 1'b0;
   endtask
   always @(posedge clk) begin
      if (br && bv || rr && rv) chk("bus answer", q.pop_front(), br ? {bresp, 32'h0} : {rresp, rd});
   end
   // Random word with every select kept to a documented code
   function automatic logic [31:0] legal(input int s);
      pcs_cfg_t c;
      c = pcs_cfg_t'($random(seed));
      c.feedback_source_select = 2'(s % 3 + 1);
      c.primary_output_select = (s == 3) ? 3'h4 : 3'(s);
      c.secondary_output_select = 2'(s);
      c.primary_output_delay = 2'(s);
      c.secondary_output_delay = 2'(~s);
      return c;
   endfunction
   initial begin
      {rstn, awv, wv, br, arv, rr, awa, ara, wd} = '0;
      ref_ok = 1'b1;
      ph_ok = 1'b1;
      seed = 32'hC4FEE9B3;
      error_cnt = 0;
      total_checks = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      xfer(1'b0, ADDR_FIXED, 32'h0, {RESP_OKAY, FIXED_RST});
      xfer(1'b0, ADDR_ACTIVE, 32'h0, {RESP_OKAY, FIXED_RST});
      xfer(1'b1, 12'h020, 32'hFFFF_FFFF, {RESP_SLVERR, 32'h0});
      xfer(1'b0, 12'h020, 32'h0, {RESP_SLVERR, 32'h0});
      $display("reset test done");
      for (i = 0; i < 8; i++) begin
         f = legal(i);
         xfer(1'b1, ADDR_FIXED, f, WOK);
         repeat (3) @(posedge clk);
         xfer(1'b0, ADDR_ACTIVE, 32'h0, {RESP_OKAY, f});
      end
      $display("fixed settings test done");
      for (i = 0; i < 2; i++) begin
         n = 0;
         while (lock !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
         end
         chk("lock high", 34'h1, {33'h0, lock});
         xfer(1'b0, ADDR_STATUS, 32'h0, {RESP_OKAY, 32'h9});
         if (i == 0) ph_ok <= 1'b0;
         else ref_ok <= 1'b0;
         repeat (8) @(posedge clk);
         chk("lock low", 34'h0, {33'h0, lock});
         ref_ok <= 1'b1;
         ph_ok <= 1'b1;
      end
      $display("lock test done");
      w = legal(5);
      xfer(1'b1, ADDR_CTRL, 32'h1, WOK);
      ldr.load(w, 1'b0);
      repeat (4) @(posedge clk);
      xfer(1'b0, ADDR_SHIFT, 32'h0, {RESP_OKAY, w});
      xfer(1'b0, ADDR_ACTIVE, 32'h0, {RESP_OKAY, w});
      w = legal(6);
      xfer(1'b1, ADDR_CTRL, 32'h3, WOK);
      ldr.load(w, 1'b1);
      repeat (8) @(posedge clk);
      xfer(1'b0, ADDR_ACTIVE, 32'h0, {RESP_OKAY, w});
      w = legal(7);
      xfer(1'b1, ADDR_SHIFT, w, WOK);
      xfer(1'b1, ADDR_CTRL, 32'h5, WOK);
      repeat (3) @(posedge clk);
      xfer(1'b0, ADDR_ACTIVE, 32'h0, {RESP_OKAY, w});
      xfer(1'b0, ADDR_CTRL, 32'h0, {RESP_OKAY, 32'h1});
      $display("dynamic load test done");
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
endmodule
